/* File: ssi_pkg.sv */
// What this block does
// - Matched write address clears read/write bit and loads address into buffer.
// - Address byte gets no acknowledge while buffer full or overflow flag set.
// - Every data byte raises the port flag; software clears it and reads status.
// - Data byte received while buffer unread sets overflow and is not acknowledged.
// - Matched read address sets read/write bit and loads address into buffer.
// - Matched read address is acknowledged, then bus clock is held low.
// - Software queues transmit byte in the FIFO for the shift register, then releases the clock.
// - Transmitter shifts eight bits, changing data on bus clock falling edges.
// - Transmitter raises the port flag on the ninth falling clock edge.
// - Transmitter samples the master acknowledge on the ninth rising clock edge.
// - Master not acknowledging ends transfer, resets slave status, awaits start.
// - Start and stop seen bits clear on reset or disable, track bus conditions.
// - Direction bit set to output drives the pin low, whatever the latch holds.
// - Port flag is raised on start, stop and every byte moved.
// - A mode value idles the slave for firmware master; master may share active slave.
// - Shift bits 7..1 are compared to own address on eighth falling edge.
// - Buffer read clears the full flag; only software clears the overflow flag.
// - Everything except the transmit FIFO works only while the port enable bit is set.
package ssi_pkg;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam logic [3:0] MODE_FW_MASTER = 4'hb;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [1:0] PINS_RST = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_TXACK
  } ssi_state_e;
endpackage

/* File: ssi_stream_if.sv */
`timescale 1ns/100ps
interface ssi_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface // ssi_stream_if

/* File: ssi_sync.sv */
`timescale 1ns/100ps
module ssi_sync import ssi_pkg::*; #(parameter int W = 2) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Data
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta;

  // Bus idles high, so reset to released level avoids a false start
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta <= W'(PINS_RST);
      sync_o <= W'(PINS_RST);
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule // ssi_sync

/* File: ssi_fifo.sv */
`timescale 1ns/100ps
module ssi_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Streams
  ssi_stream_if.snk in_s,
  ssi_stream_if.src out_s
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  logic in_rdy;

  // Ready is a flop so the top-level ready output comes straight from a register
  assign in_s.ready = in_rdy;
  assign out_s.valid = (count != '0);
  assign out_s.data = mem[rptr];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wptr] <= in_s.data;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      in_rdy <= 1'b1;
    end else begin
      if (push) begin
        wptr <= (wptr == PTR_LAST) ? '0 : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == PTR_LAST) ? '0 : rptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
        in_rdy <= ((count + 1'b1) != CNT_FULL);
      end else if (pop && !push) begin
        count <= count - 1'b1;
        in_rdy <= 1'b1;
      end
    end
  end
endmodule // ssi_fifo

/* File: ssi_i2c_slave.sv */
`timescale 1ns/100ps
module ssi_i2c_slave import ssi_pkg::*; (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Bus pins, open drain
  input wire logic bus_clock_pin_i,
  output logic bus_clock_pin_o,
  output logic bus_clock_pin_oe_o,
  input wire logic bus_data_pin_i,
  output logic bus_data_pin_o,
  output logic bus_data_pin_oe_o,
  // Control
  input wire logic port_enable_bit_i,
  input wire logic [3:0] port_mode_field_i,
  input wire logic [6:0] own_address_reg_i,
  input wire logic [1:0] pin_direction_reg_i,
  input wire logic clock_release_i,
  // Software strobes
  input wire logic buffer_read_i,
  input wire logic overflow_clear_i,
  input wire logic irq_clear_i,
  // Transmit byte path
  input wire logic [7:0] tx_data_i,
  input wire logic tx_write_i,
  output logic tx_ready_o,
  // Status
  output logic [7:0] rx_tx_buffer_o,
  output logic buffer_full_flag_o,
  output logic receive_overflow_flag_o,
  output logic port_irq_flag_o,
  output logic read_write_bit_o,
  output logic data_not_addr_o,
  output logic start_seen_o,
  output logic stop_seen_o,
  output logic clock_held_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation and bus event detection

  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic scl_q;
  logic sda_q;

  ssi_sync #(.W(2)) u_sync (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .async_i({bus_data_pin_i, bus_clock_pin_i}),
    .sync_o(pins_s)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic enabled;
  logic slave_on;

  assign scl_rise = scl_s && !scl_q;
  assign scl_fall = !scl_s && scl_q;
  assign start_ev = scl_s && scl_q && sda_q && !sda_s;
  assign stop_ev = scl_s && scl_q && !sda_q && sda_s;
  assign enabled = port_enable_bit_i;
  assign slave_on = enabled && (port_mode_field_i != MODE_FW_MASTER);

  ////////////////////////////////////////////////////////////////////////////
  // Transmit FIFO

  ssi_stream_if #(.W(DATA_W)) tx_in ();
  ssi_stream_if #(.W(DATA_W)) tx_out ();

  assign tx_in.data = tx_data_i;
  assign tx_in.valid = tx_write_i;
  assign tx_ready_o = tx_in.ready;

  ssi_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .in_s(tx_in.snk),
    .out_s(tx_out.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequence state

  ssi_state_e state;
  logic [3:0] cnt;
  logic [7:0] shreg;
  logic is_addr;
  logic ack_drive;
  logic stretch;
  logic tx_loaded;
  logic master_nack;
  logic bf;
  logic ov;

  logic byte_end;
  logic addr_hit;
  logic accept;
  logic rx_take;
  logic rx_ovf;
  logic ack_end;
  logic txack_end;
  logic tx_pop;
  logic tx_load;

  assign byte_end = (state == ST_RX) && scl_fall && (cnt == BIT_LAST);
  assign addr_hit = is_addr && (shreg[7:1] == own_address_reg_i);
  assign accept = !bf && !ov;
  assign rx_take = byte_end && (addr_hit || !is_addr) && accept;
  assign rx_ovf = byte_end && !is_addr && !accept;
  assign ack_end = (state == ST_ACK) && scl_fall;
  assign txack_end = (state == ST_TXACK) && scl_fall;
  // Pops only while stretched and empty, so queued bytes wait in the FIFO
  assign tx_pop = (state == ST_TX) && stretch && !tx_loaded;
  assign tx_out.ready = tx_pop;
  assign tx_load = tx_pop && tx_out.valid;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_IDLE;
      cnt <= CNT_RST;
      shreg <= BYTE_RST;
      is_addr <= 1'b0;
      ack_drive <= 1'b0;
      stretch <= 1'b0;
      tx_loaded <= 1'b0;
      master_nack <= 1'b0;
    end else if (!slave_on || stop_ev) begin
      state <= ST_IDLE;
      cnt <= CNT_RST;
      ack_drive <= 1'b0;
      stretch <= 1'b0;
      tx_loaded <= 1'b0;
    end else if (start_ev) begin
      // Repeated start also restarts address reception
      state <= ST_RX;
      cnt <= CNT_RST;
      is_addr <= 1'b1;
      ack_drive <= 1'b0;
      stretch <= 1'b0;
      tx_loaded <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          cnt <= CNT_RST;
        end
        ST_RX: begin
          if (scl_rise && (cnt != BIT_LAST)) begin
            shreg <= {shreg[6:0], sda_s};
            cnt <= cnt + 4'h1;
          end
          if (byte_end) begin
            if (is_addr && !addr_hit) begin
              state <= ST_IDLE;
            end else begin
              state <= ST_ACK;
              ack_drive <= accept;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            ack_drive <= 1'b0;
            cnt <= CNT_RST;
            if (is_addr && !ack_drive) begin
              state <= ST_IDLE;
            end else if (is_addr && shreg[0]) begin
              state <= ST_TX;
              stretch <= 1'b1;
              tx_loaded <= 1'b0;
            end else begin
              state <= ST_RX;
            end
            is_addr <= 1'b0;
          end
        end
        ST_TX: begin
          if (tx_load) begin
            shreg <= tx_out.data;
            tx_loaded <= 1'b1;
          end
          if (stretch && tx_loaded && clock_release_i) begin
            stretch <= 1'b0;
          end
          if (!stretch && scl_rise) begin
            cnt <= cnt + 4'h1;
          end
          if (!stretch && scl_fall) begin
            if (cnt == BIT_LAST) begin
              state <= ST_TXACK;
            end else begin
              shreg <= {shreg[6:0], 1'b0};
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise) begin
            master_nack <= sda_s;
          end
          if (scl_fall) begin
            cnt <= CNT_RST;
            if (master_nack) begin
              state <= ST_IDLE;
            end else begin
              state <= ST_TX;
              stretch <= 1'b1;
              tx_loaded <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer and overflow flags

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_tx_buffer_o <= BYTE_RST;
      bf <= 1'b0;
      ov <= 1'b0;
    end else if (!enabled) begin
      bf <= 1'b0;
      ov <= 1'b0;
    end else begin
      if (rx_take) begin
        rx_tx_buffer_o <= shreg;
      end
      if (rx_take) begin
        bf <= 1'b1;
      end else if (txack_end && master_nack) begin
        bf <= 1'b0;
      end else if (buffer_read_i) begin
        bf <= 1'b0;
      end
      if (rx_ovf) begin
        ov <= 1'b1;
      end else if (overflow_clear_i) begin
        ov <= 1'b0;
      end
    end
  end

  assign buffer_full_flag_o = bf;
  assign receive_overflow_flag_o = ov;

  ////////////////////////////////////////////////////////////////////////////
  // Status bits

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      read_write_bit_o <= 1'b0;
      data_not_addr_o <= 1'b0;
    end else if (!slave_on || (txack_end && master_nack)) begin
      read_write_bit_o <= 1'b0;
      data_not_addr_o <= 1'b0;
    end else if (byte_end && addr_hit) begin
      read_write_bit_o <= shreg[0];
      data_not_addr_o <= 1'b0;
    end else if (rx_take) begin
      data_not_addr_o <= 1'b1;
    end else if (tx_load) begin
      data_not_addr_o <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      start_seen_o <= 1'b0;
      stop_seen_o <= 1'b0;
    end else if (!enabled) begin
      start_seen_o <= 1'b0;
      stop_seen_o <= 1'b0;
    end else if (start_ev) begin
      start_seen_o <= 1'b1;
      stop_seen_o <= 1'b0;
    end else if (stop_ev) begin
      start_seen_o <= 1'b0;
      stop_seen_o <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      port_irq_flag_o <= 1'b0;
    end else if (!enabled) begin
      port_irq_flag_o <= 1'b0;
    end else if (start_ev || stop_ev) begin
      port_irq_flag_o <= 1'b1;
    end else if (slave_on && (ack_end || txack_end)) begin
      port_irq_flag_o <= 1'b1;
    end else if (irq_clear_i) begin
      port_irq_flag_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers

  logic tx_bit_low;

  assign tx_bit_low = (state == ST_TX) && tx_loaded && !shreg[7];

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_clock_pin_o <= 1'b0;
      bus_data_pin_o <= 1'b0;
      bus_clock_pin_oe_o <= 1'b0;
      bus_data_pin_oe_o <= 1'b0;
      clock_held_o <= 1'b0;
    end else begin
      bus_clock_pin_o <= 1'b0;
      bus_data_pin_o <= 1'b0;
      bus_clock_pin_oe_o <= enabled && (!pin_direction_reg_i[0] || stretch);
      bus_data_pin_oe_o <= enabled && (!pin_direction_reg_i[1] || tx_bit_low
                           || ((state == ST_ACK) && ack_drive));
      clock_held_o <= stretch;
    end
  end

endmodule // ssi_i2c_slave

/* File: ssi_i2c_slave_chk.sv */
`timescale 1ns/100ps
module ssi_i2c_slave_chk (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Control
  input wire logic port_enable_bit_i,
  input wire logic [1:0] pin_direction_reg_i,
  input wire logic clock_release_i,
  input wire logic overflow_clear_i,
  // Pins and status
  input wire logic bus_clock_pin_o,
  input wire logic bus_clock_pin_oe_o,
  input wire logic bus_data_pin_o,
  input wire logic bus_data_pin_oe_o,
  input wire logic [7:0] rx_tx_buffer_o,
  input wire logic buffer_full_flag_o,
  input wire logic receive_overflow_flag_o,
  input wire logic port_irq_flag_o,
  input wire logic read_write_bit_o,
  input wire logic data_not_addr_o,
  input wire logic start_seen_o,
  input wire logic stop_seen_o,
  input wire logic clock_held_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_stop;
    $rose(stop_seen_o);
  endsequence
  sequence s_addr_in;
    $rose(buffer_full_flag_o) && !data_not_addr_o;
  endsequence

  ////////////////////////////////////////
  low_only_a: assert property (!bus_clock_pin_o && !bus_data_pin_o)
    else $error("bus pin driven high");
  dis_clear_a: assert property (!port_enable_bit_i |=> !start_seen_o && !stop_seen_o
    && !port_irq_flag_o) else $error("flags kept while disabled");
  dir_clock_a: assert property (port_enable_bit_i && !pin_direction_reg_i[0]
    |=> bus_clock_pin_oe_o) else $error("clock not pulled low");
  dir_data_a: assert property (port_enable_bit_i && !pin_direction_reg_i[1]
    |=> bus_data_pin_oe_o) else $error("data not pulled low");
  stop_flag_a: assert property (s_stop |-> port_irq_flag_o)
    else $error("no flag on stop");
  ovf_noack_a: assert property ($rose(receive_overflow_flag_o) && pin_direction_reg_i[1]
    |-> !bus_data_pin_oe_o [*3]) else $error("overflowed byte acknowledged");
  ovf_hold_a: assert property (receive_overflow_flag_o && !overflow_clear_i
    && port_enable_bit_i |=> receive_overflow_flag_o) else $error("overflow lost");
  // Held flag trails the internal stretch by one cycle, so a release one back still counts
  stretch_hold_a: assert property (clock_held_o && !clock_release_i
    && !$past(clock_release_i) && port_enable_bit_i |=> clock_held_o)
    else $error("stretch ended early");
  addr_dir_a: assert property (s_addr_in |-> rx_tx_buffer_o[0] == read_write_bit_o)
    else $error("direction bit mismatch");
endmodule // ssi_i2c_slave_chk

bind ssi_i2c_slave ssi_i2c_slave_chk ssi_i2c_slave_chk_i (
  .mclk_i, .rst_b_i, .port_enable_bit_i, .pin_direction_reg_i, .clock_release_i,
  .overflow_clear_i, .bus_clock_pin_o, .bus_clock_pin_oe_o, .bus_data_pin_o,
  .bus_data_pin_oe_o, .rx_tx_buffer_o, .buffer_full_flag_o, .receive_overflow_flag_o,
  .port_irq_flag_o, .read_write_bit_o, .data_not_addr_o, .start_seen_o, .stop_seen_o,
  .clock_held_o
);

/* File: ssi_bus_master.sv */
`timescale 1ns/100ps
module ssi_bus_master (
  // Wire levels
  input wire logic scl_i,
  input wire logic sda_i,
  // Pull-low enables
  output logic scl_oe_o,
  output logic sda_oe_o
);
  localparam int Q = 80;
  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
  end
  ////////////////////////////////////////
  // wait out stretch
  task automatic up();
    int n;
    n = 0;
    scl_oe_o = 1'b0;
    while (scl_i !== 1'b1 && n < 5000) begin
      #10;
      n++;
    end
    #Q;
  endtask
  task automatic bit_io(input logic b, output logic s);
    sda_oe_o = !b;
    #Q;
    up();
    s = sda_i;
    #Q;
    scl_oe_o = 1'b1;
    #Q;
  endtask
  // Odd offset keeps link edges off the system clock edges
  task automatic start();
    #7;
    sda_oe_o = 1'b1;
    #Q;
    scl_oe_o = 1'b1;
    #Q;
  endtask
  // Clock is left high afterwards: it stands still between frames
  task automatic stop();
    sda_oe_o = 1'b1;
    #Q;
    up();
    sda_oe_o = 1'b0;
    #Q;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
    output logic ao);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
      q[i] = s;
    end
    bit_io(ai, ao);
  endtask
endmodule // ssi_bus_master

/* File: test_ssi_i2c_slave.sv */
`timescale 1ns/100ps
module test_ssi_i2c_slave import ssi_pkg::*;;
  logic mclk = 1'b0, rst_b = 1'b0, en = 1'b0, rel = 1'b0, tx_wr = 1'b0, ack;
  logic [3:0] mode = 4'h6;
  logic [6:0] adr = 7'h00;
  logic [1:0] dir = 2'h3;
  logic [2:0] sw = 3'h0;
  logic [7:0] tx_d = 8'h00, q, t0, t1, buf_o;
  logic c_oe, d_oe, m_c, m_d, tx_rdy, full, ovf, irq, rw, dna, st, sp, held;
  int n_fail = 0, tests_run = 0;
  // Pull-ups: a released line reads high
  wire scl = !(c_oe || m_c);
  wire sda = !(d_oe || m_d);

  always #20 mclk = !mclk;

  ssi_i2c_slave ssi_i2c_slave_i (
    .mclk_i(mclk), .rst_b_i(rst_b), .bus_clock_pin_i(scl), .bus_clock_pin_o(),
    .bus_clock_pin_oe_o(c_oe), .bus_data_pin_i(sda), .bus_data_pin_o(),
    .bus_data_pin_oe_o(d_oe), .port_enable_bit_i(en), .port_mode_field_i(mode),
    .own_address_reg_i(adr), .pin_direction_reg_i(dir), .clock_release_i(rel),
    .buffer_read_i(sw[0]), .overflow_clear_i(sw[1]), .irq_clear_i(sw[2]),
    .tx_data_i(tx_d), .tx_write_i(tx_wr), .tx_ready_o(tx_rdy), .rx_tx_buffer_o(buf_o),
    .buffer_full_flag_o(full), .receive_overflow_flag_o(ovf), .port_irq_flag_o(irq),
    .read_write_bit_o(rw), .data_not_addr_o(dna), .start_seen_o(st), .stop_seen_o(sp),
    .clock_held_o(held)
  );
  ssi_bus_master ssi_bus_master_i (.scl_i(scl), .sda_i(sda), .scl_oe_o(m_c), .sda_oe_o(m_d));

  ////////////////////////////////////////
  function automatic logic [7:0] abyte(input logic [6:0] a, input logic r);
    return {a, r};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (n_fail == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic strobe(input logic [2:0] v);
    tick(1);
    sw = v;
    tick(1);
    sw = 3'h0;
  endtask
  task automatic push(input logic [7:0] d);
    tick(1);
    tx_d = d;
    tx_wr = 1'b1;
    do @(posedge mclk); while (tx_rdy !== 1'b1);
    #1 tx_wr = 1'b0;
  endtask
  task automatic send(input logic [7:0] d, input logic ai);
    ssi_bus_master_i.xfer(d, ai, q, ack);
    tick(6);
  endtask

  initial forever begin
    @(posedge mclk);
    if (held === 1'b1) begin
      repeat ($urandom_range(20, 12)) @(posedge mclk);
      #1 rel = 1'b1;
      @(posedge mclk);
      #1 rel = 1'b0;
    end
  end

  initial begin
    #1000000;
    n_fail++;
    give_verdict();
  end

  ////////////////////////////////////////
  initial begin
    void'($urandom(48793));
    adr = 7'($urandom());
    t0 = 8'($urandom());
    t1 = 8'($urandom());
    repeat (20) @(posedge mclk);
    #1 rst_b = 1'b1;
    en = 1'b1;
    tick(3);
    chk({2'h0, st, sp, irq, full, c_oe, d_oe}, 8'h00);
    ssi_bus_master_i.start();
    tick(6);
    chk({st, irq}, 8'h03);
    strobe(3'h4);
    send(abyte(adr, 1'b0), 1'b1);
    chk({ack, rw, full, irq}, 8'h03);
    chk(buf_o, abyte(adr, 1'b0));
    strobe(3'h4);
    send(t0, 1'b1);
    chk({ack, ovf, irq}, 8'h07);
    chk(buf_o, abyte(adr, 1'b0));
    strobe(3'h5);
    chk({full, ovf}, 8'h01);
    send(t0, 1'b1);
    chk({ack, ovf}, 8'h03);
    strobe(3'h6);
    send(t0, 1'b1);
    chk({ack, full, dna, irq}, 8'h07);
    chk(buf_o, t0);
    ssi_bus_master_i.stop();
    tick(6);
    chk({st, sp}, 8'h01);
    ssi_bus_master_i.start();
    send(abyte(adr, 1'b0), 1'b1);
    chk({ack, ovf}, 8'h02);
    ssi_bus_master_i.stop();
    strobe(3'h5);
    for (int k = 0; k < 7; k++) begin
      ssi_bus_master_i.start();
      send(abyte(adr ^ (7'h01 << k), 1'b0), 1'b1);
      chk({ack, full}, 8'h02);
      ssi_bus_master_i.stop();
    end
    push(t0);
    push(t1);
    ssi_bus_master_i.start();
    send(abyte(adr, 1'b1), 1'b1);
    chk({ack, rw, full, held, c_oe}, 8'h0f);
    chk(buf_o, abyte(adr, 1'b1));
    strobe(3'h5);
    send(8'hff, 1'b0);
    chk(q, t0);
    chk(irq, 1'b1);
    send(8'hff, 1'b1);
    chk(q, t1);
    chk({rw, full, dna}, 8'h00);
    ssi_bus_master_i.stop();
    tick(1);
    mode = MODE_FW_MASTER;
    ssi_bus_master_i.start();
    send(abyte(adr, 1'b0), 1'b1);
    chk({st, ack, full}, 8'h06);
    ssi_bus_master_i.stop();
    tick(1);
    dir = 2'h0;
    tick(3);
    chk({c_oe, d_oe, scl, sda}, 8'h0c);
    dir = 2'h3;
    en = 1'b0;
    tick(3);
    chk({st, sp, irq}, 8'h00);
    give_verdict();
  end
endmodule // test_ssi_i2c_slave
